// [ecp_consts.vh]
`ifndef ECP_CONSTS_VH
`define ECP_CONSTS_VH

// ----------------------------------------
// Address map (byte offsets)
// ----------------------------------------
`define ECP_ADDR_W 8
`define ECP_OFS_CAP_PARAMS 8'h08
`define ECP_OFS_COMMAND 8'h0C

// ----------------------------------------
// Capability parameter fields
// ----------------------------------------
`define ECP_IST_HI 7
`define ECP_IST_LO 4
`define ECP_IST_W 4
`define ECP_PROG_FRAME_LIST_FLAG_BIT 1
`define ECP_WIDE_BIT 0
`define ECP_IST_RST 4'h1
`define ECP_PROG_FRAME_LIST_FLAG_RST 1'h1
`define ECP_WIDE_RST 1'h0
`define ECP_IST_FULL_BIT 3
`define ECP_HOLD_HI 2
`define ECP_HOLD_LO 0
`define ECP_HOLD_W 3
`define ECP_HOLD_NONE 3'h0
`define ECP_DATA_W 32

// ----------------------------------------
// Command register frame list size field
// ----------------------------------------
`define ECP_FLS_HI 3
`define ECP_FLS_LO 2
`define ECP_FLS_W 2
`define ECP_FLS_RST 2'h0
`define ECP_FLS_ENTRIES_1024 2'h0

`define ECP_ZERO32 32'h00000000

`endif

// [ecp_fls_field.v]
`timescale 1ns/100ps
`include "ecp_consts.vh"

// ----------------------------------------
// Frame list size field store
// ----------------------------------------
module ecp_fls_field (
    input wire i_core_clk, // System clock
    input wire i_nrst, // Sync reset, active low
    input wire i_ce, // Clock enable
    input wire i_prog_frame_list_flag, // Field is writable
    input wire i_wr, // Write this field
    input wire [`ECP_FLS_W-1:0] i_wdata, // New field value
    output wire [`ECP_FLS_W-1:0] o_frame_list_size // Current field value
);
    reg [`ECP_FLS_W-1:0] fls_reg;
    reg [`ECP_FLS_W-1:0] fls_next;

    always @*
    begin
        fls_next = fls_reg;
        if (!i_prog_frame_list_flag)
            fls_next = `ECP_FLS_ENTRIES_1024;
        else if (i_wr)
            fls_next = i_wdata;
    end

    always @(posedge i_core_clk)
    begin
        if (!i_nrst)
            fls_reg <= `ECP_FLS_RST;
        else if (i_ce)
            fls_reg <= fls_next;
    end

    assign o_frame_list_size = fls_reg;
endmodule

// [ecp_capability_params.v]
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "ecp_consts.vh"

module ecp_capability_params (
    input wire i_core_clk, // System clock, 20 MHz
    input wire i_nrst, // Sync reset, active low
    input wire i_ce, // Clock enable
    input wire [`ECP_ADDR_W-1:0] i_addr, // Byte address
    input wire [31:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    output reg [31:0] o_rdata, // Read data, cycle after strobe
    output wire [`ECP_IST_W-1:0] o_iso_sched_threshold, // Threshold
    output wire o_iso_full_frame, // Threshold means whole frame
    output wire [2:0] o_iso_hold_uframes, // Micro frames held
    output wire o_prog_frame_list_flag, // Frame list programmable
    output wire o_wide_pointer_capable, // 64-bit pointers
    output wire [`ECP_FLS_W-1:0] o_frame_list_size // Command field
);
    // ----------------------------------------
    // Capability word
    // ----------------------------------------
    // Constant fields, held in flops so reset defines them
    reg [`ECP_IST_W-1:0] ist_reg;
    reg prog_frame_list_flag_reg;
    reg wide_reg;
    reg [`ECP_HOLD_W-1:0] hold_uframes;
    reg [`ECP_DATA_W-1:0] rdata_next;
    wire [`ECP_DATA_W-1:0] cap_word;
    wire [`ECP_DATA_W-1:0] cmd_word;
    wire cap_hit;
    wire cmd_hit;
    wire cmd_wr;
    wire [`ECP_FLS_W-1:0] fls;
    genvar gb;

    always @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            ist_reg <= `ECP_IST_RST;
            prog_frame_list_flag_reg <= `ECP_PROG_FRAME_LIST_FLAG_RST;
            wide_reg <= `ECP_WIDE_RST;
        end
    end
    // No write path to these flops at all

    generate
        for (gb = 0; gb < `ECP_DATA_W; gb = gb + 1)
        begin : g_word_bit
            // Placement follows the bit constants only
            if (gb >= `ECP_IST_LO && gb <= `ECP_IST_HI)
            begin : g_ist
                assign cap_word[gb] = ist_reg[gb-`ECP_IST_LO];
            end
            else if (gb == `ECP_PROG_FRAME_LIST_FLAG_BIT)
            begin : g_prog_frame_list_flag
                assign cap_word[gb] = prog_frame_list_flag_reg;
            end
            else if (gb == `ECP_WIDE_BIT)
            begin : g_wide
                assign cap_word[gb] = wide_reg;
            end
            else
            begin : g_cap_rsvd
                assign cap_word[gb] = 1'b0;
            end
            if (gb >= `ECP_FLS_LO && gb <= `ECP_FLS_HI)
            begin : g_fls
                assign cmd_word[gb] = fls[gb-`ECP_FLS_LO];
            end
            else
            begin : g_cmd_rsvd
                assign cmd_word[gb] = 1'b0;
            end
        end
    endgenerate

    assign o_iso_sched_threshold = ist_reg;
    assign o_iso_full_frame = ist_reg[`ECP_IST_FULL_BIT];

    // Count means nothing once the full-frame bit is set
    always @*
    begin
        hold_uframes = ist_reg[`ECP_HOLD_HI:`ECP_HOLD_LO];
        if (ist_reg[`ECP_IST_FULL_BIT])
            hold_uframes = `ECP_HOLD_NONE;
    end
    assign o_iso_hold_uframes = hold_uframes;
    assign o_prog_frame_list_flag = prog_frame_list_flag_reg;
    assign o_wide_pointer_capable = wide_reg;

    // ----------------------------------------
    // Command frame list size field
    // ----------------------------------------
    // Frame list base alignment is software's duty; not checked
    assign cap_hit = (i_addr == `ECP_OFS_CAP_PARAMS);
    assign cmd_hit = (i_addr == `ECP_OFS_COMMAND);
    // Writes that hit the parameter word go nowhere
    assign cmd_wr = i_wr && cmd_hit;

    ecp_fls_field u_fls (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_prog_frame_list_flag(prog_frame_list_flag_reg),
        .i_wr(cmd_wr),
        .i_wdata(i_wdata[`ECP_FLS_HI:`ECP_FLS_LO]),
        .o_frame_list_size(fls)
    );
    assign o_frame_list_size = fls;

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Idle cycles with i_ce high read as zero; while i_ce is low o_rdata keeps its last word
    always @*
    begin
        rdata_next = `ECP_ZERO32;
        if (i_rd && cap_hit)
            rdata_next = cap_word;
        else if (i_rd && cmd_hit)
            rdata_next = cmd_word;
    end

    always @(posedge i_core_clk)
    begin
        if (!i_nrst)
            o_rdata <= `ECP_ZERO32;
        else if (i_ce)
            o_rdata <= rdata_next;
    end
endmodule

// [ecp_capability_params_assertions.sv]
`timescale 1ns/100ps
module ecp_cap_chk (
    input wire i_core_clk, // Clock
    input wire i_nrst, // Reset, active low
    input wire i_ce, // Clock enable
    input wire [7:0] i_addr, // Address
    input wire [31:0] i_wdata, // Write data
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    input wire [31:0] o_rdata, // Read data
    input wire [3:0] o_iso_sched_threshold, // Threshold
    input wire o_iso_full_frame, // Whole frame
    input wire [2:0] o_iso_hold_uframes, // Hold count
    input wire o_prog_frame_list_flag, // Size writable
    input wire o_wide_pointer_capable, // Pointer width
    input wire [1:0] o_frame_list_size // Size field
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    wire rd_go = i_rd && i_ce;
    wire wr_go = i_wr && i_ce;
    AST_CAP_READ: assert property (rd_go && i_addr == 8'h08
        |=> o_rdata == 32'h00000012) else $error("param word wrong");
    AST_IST_VALUE: assert property (o_iso_sched_threshold == 4'h1)
        else $error("threshold wrong");
    AST_HOLD_COUNT: assert property (!o_iso_full_frame
        |-> o_iso_hold_uframes == o_iso_sched_threshold[2:0])
        else $error("hold count wrong");
    AST_FULL_FRAME: assert property (o_iso_full_frame ==
        o_iso_sched_threshold[3]) else $error("full frame wrong");
    AST_FLAG_SET: assert property (o_prog_frame_list_flag)
        else $error("flag not set");
    AST_NARROW_PTR: assert property (!o_wide_pointer_capable)
        else $error("pointer width wrong");
    AST_SIZE_WRITE: assert property (wr_go && i_addr == 8'h0C
        |=> o_frame_list_size == $past(i_wdata[3:2]))
        else $error("size write lost");
    AST_CAP_NO_WRITE: assert property (wr_go && i_addr == 8'h08
        |=> $stable(o_frame_list_size) && $stable(o_iso_sched_threshold)
        && $stable(o_prog_frame_list_flag)
        && $stable(o_wide_pointer_capable)) else $error("write leaked");
    AST_RDATA_IDLE: assert property (!i_rd && i_ce
        |=> o_rdata == 32'h0) else $error("read data not zero");
    AST_CMD_READ: assert property (rd_go && i_addr == 8'h0C
        |=> o_rdata == {28'h0000000, $past(o_frame_list_size), 2'h0})
        else $error("command read wrong");
    AST_RSVD_READ: assert property (rd_go && i_addr != 8'h08
        && i_addr != 8'h0C |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CE_FREEZE: assert property (!i_ce |=> $stable(o_rdata)
        && $stable(o_frame_list_size))
        else $error("state moved with enable low");
endmodule

// [tb_ehci_capability_params.sv]
`timescale 1ns/100ps
module tb_ehci_capability_params;
    reg i_core_clk = 0, i_nrst = 0, i_ce = 1, i_wr = 0, i_rd = 0;
    reg [7:0] i_addr = 8'h00;
    reg [31:0] i_wdata = 32'h00000000, d;
    wire [31:0] o_rdata;
    wire [3:0] o_iso_sched_threshold;
    wire [2:0] o_iso_hold_uframes;
    wire [1:0] o_frame_list_size;
    wire o_iso_full_frame, o_prog_frame_list_flag, o_wide_pointer_capable;
    integer fails = 0, samples_checked = 0;
    ecp_capability_params i_dut (.i_core_clk, .i_nrst, .i_ce, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .o_iso_sched_threshold,
        .o_iso_full_frame, .o_iso_hold_uframes, .o_prog_frame_list_flag,
        .o_wide_pointer_capable, .o_frame_list_size);
    initial forever #25 i_core_clk = ~i_core_clk;
    // ----------------------------------------
    // Bus tasks and scenarios
    // ----------------------------------------
    // Frame list base alignment is software's; no base is written
    task chk(input [31:0] g, input [31:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) fails = fails + 1;
        if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge i_core_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_core_clk) i_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_core_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_core_clk) i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task t_reset_values;
        rd(8'h08);
        chk(d, 32'h00000012);
        chk({26'h0, o_iso_full_frame, o_iso_hold_uframes,
            o_prog_frame_list_flag, o_wide_pointer_capable}, 32'h6);
        chk({28'h0, o_iso_sched_threshold}, 32'h1);
        chk({30'h0, o_frame_list_size}, 32'h0);
    endtask
    task t_write_ignored;
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08);
        chk(d, 32'h00000012);
    endtask
    task t_size_field;
        wr(8'h0C, 32'h00000008);
        rd(8'h0C);
        chk(d, 32'h00000008);
        chk({30'h0, o_frame_list_size}, 32'h2);
        rd(8'h40);
        chk(d, 32'h00000000);
    endtask
    task t_ce_freeze;
        @(posedge i_core_clk) i_ce <= 1'b0;
        wr(8'h0C, 32'h00000000);
        rd(8'h08);
        chk(d, 32'h00000000);
        chk({30'h0, o_frame_list_size}, 32'h2);
        @(posedge i_core_clk) i_ce <= 1'b1;
    endtask
    task t_mid_reset;
        @(posedge i_core_clk) i_nrst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        #1 chk({30'h0, o_frame_list_size}, 32'h0);
        rd(8'h08);
        chk(d, 32'h00000012);
    endtask
    task tally_and_finish;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_reset_values;
        t_write_ignored;
        t_size_field;
        t_ce_freeze;
        t_mid_reset;
        tally_and_finish;
    end
    initial
    begin
        #100000 fails = fails + 1;
        tally_and_finish;
    end
endmodule
bind ecp_capability_params ecp_cap_chk i_chk (.i_core_clk, .i_nrst,
    .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_iso_sched_threshold, .o_iso_full_frame, .o_iso_hold_uframes,
    .o_prog_frame_list_flag, .o_wide_pointer_capable, .o_frame_list_size);
